// ===== src/cbu_pkg.sv
// Purpose: shared constants and types for the conditional branch unit
// Assumes: 16-bit word program counter, 7-bit signed branch offset
// Notes: flag positions follow the core status byte layout
package cbu_pkg;
	localparam int PC_W = 16;
	localparam int OFS_W = 7;
	localparam logic [PC_W-1:0] PC_RST = 16'h0000;
	localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
	localparam logic [7:0] SREG_RST = 8'h00;
	// status byte bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;

	// branch selector codes presented by the instruction decoder
	typedef enum logic [3:0] {
		CBU_NONE = 4'h0,
		CBU_CARRY_SET = 4'h1,
		CBU_CARRY_CLR = 4'h2,
		CBU_UNS_GE = 4'h3,
		CBU_UNS_LT = 4'h4,
		CBU_NEG = 4'h5,
		CBU_POS = 4'h6,
		CBU_SGN_GE = 4'h7,
		CBU_SGN_LT = 4'h8,
		CBU_HALF_SET = 4'h9,
		CBU_HALF_CLR = 4'hA,
		CBU_XFER_SET = 4'hB,
		CBU_XFER_CLR = 4'hC,
		CBU_OVF_SET = 4'hD
	} cbu_op_e;

	typedef enum logic [0:0] {
		CBU_RUN = 1'b0,
		CBU_FLUSH = 1'b1
	} cbu_state_e;

	typedef struct packed {
		cbu_op_e op;
		logic signed [OFS_W-1:0] offset;
	} cbu_req_s;

	typedef struct packed {
		cbu_state_e st;
		logic [PC_W-1:0] pc;
		logic taken;
		logic flush;
		logic busy;
		logic [7:0] sreg;
	} cbu_state_s;
endpackage : cbu_pkg

// ===== src/cbu_branch.sv
// Purpose: decode and execute relative conditional branches on status flags
// Assumes: decoder presents one branch per cycle with req_valid; sreg_in is live
// Notes: status flags pass through untouched
// Overview of operation
// RQ1: carry set branches when carry is one
// RQ2: carry clear branches when carry is zero
// RQ3: unsigned same-or-higher equals carry clear
// RQ4: unsigned lower equals carry set
// RQ5: negative branch when negative flag one
// RQ6: positive branch when negative flag zero
// RQ7: signed ge when n xor v zero
// RQ8: signed lt when n xor v one
// RQ9: half-carry set branch when h one
// RQ10: half-carry clear branch when h zero
// RQ11: transfer set branch when t one
// RQ12: transfer clear branch when t zero
// RQ13: branches never alter any status flag
// RQ14: each branch takes one or two cycles
// RQ15: not taken one cycle, taken two
// RQ16: overflow set branch when v one
`timescale 1ns/100ps
`default_nettype none
module cbu_branch (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire cbu_pkg::cbu_req_s req,
	input wire logic [7:0] sreg_in,
	output logic [cbu_pkg::PC_W-1:0] program_counter,
	output logic branch_taken,
	output logic flush_fetch,
	output logic busy,
	output logic [7:0] sreg_out
);
	cbu_pkg::cbu_state_s s_q;
	cbu_pkg::cbu_state_s s_d;
	logic cond;
	logic accept;
	logic [cbu_pkg::PC_W-1:0] ofs_ext;

	// sign-extend the word offset first so backward branches wrap the pc correctly
	assign ofs_ext = {{(cbu_pkg::PC_W-cbu_pkg::OFS_W){req.offset[cbu_pkg::OFS_W-1]}}, req.offset};

	always_comb begin
		logic c;
		logic n;
		logic v;
		logic h;
		logic t;
		c = sreg_in[cbu_pkg::FLAG_C];
		n = sreg_in[cbu_pkg::FLAG_N];
		v = sreg_in[cbu_pkg::FLAG_V];
		h = sreg_in[cbu_pkg::FLAG_H];
		t = sreg_in[cbu_pkg::FLAG_T];
		case (req.op)
			cbu_pkg::CBU_CARRY_SET: cond = c; // [RQ1]
			cbu_pkg::CBU_CARRY_CLR: cond = !c; // [RQ2]
			cbu_pkg::CBU_UNS_GE: cond = !c; // [RQ3]
			cbu_pkg::CBU_UNS_LT: cond = c; // [RQ4]
			cbu_pkg::CBU_NEG: cond = n; // [RQ5]
			cbu_pkg::CBU_POS: cond = !n; // [RQ6]
			cbu_pkg::CBU_SGN_GE: cond = !(n ^ v); // [RQ7]
			cbu_pkg::CBU_SGN_LT: cond = n ^ v; // [RQ8]
			cbu_pkg::CBU_HALF_SET: cond = h; // [RQ9]
			cbu_pkg::CBU_HALF_CLR: cond = !h; // [RQ10]
			cbu_pkg::CBU_XFER_SET: cond = t; // [RQ11]
			cbu_pkg::CBU_XFER_CLR: cond = !t; // [RQ12]
			cbu_pkg::CBU_OVF_SET: cond = v; // [RQ16]
			default: cond = 1'b0;
		endcase
	end

	// requests during the flush cycle are the discarded fetch and are ignored
	assign accept = req_valid && (s_q.st == cbu_pkg::CBU_RUN) && (req.op != cbu_pkg::CBU_NONE);

	always_comb begin
		s_d = s_q;
		s_d.taken = 1'b0;
		s_d.flush = 1'b0;
		s_d.busy = 1'b0;
		s_d.sreg = sreg_in; // [RQ13]
		case (s_q.st)
			cbu_pkg::CBU_RUN: begin
				if (accept && cond) begin
					// target is current pc plus sign-extended offset plus one
					s_d.pc = s_q.pc + ofs_ext + cbu_pkg::PC_STEP; // [RQ16]
					s_d.taken = 1'b1;
					s_d.flush = 1'b1;
					s_d.busy = 1'b1;
					s_d.st = cbu_pkg::CBU_FLUSH; // [RQ15]
				end else if (accept) begin
					s_d.pc = s_q.pc + cbu_pkg::PC_STEP; // [RQ14]
				end
			end
			cbu_pkg::CBU_FLUSH: begin
				s_d.st = cbu_pkg::CBU_RUN; // [RQ15]
			end
			default: s_d.st = cbu_pkg::CBU_RUN;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{st: cbu_pkg::CBU_RUN, pc: cbu_pkg::PC_RST, taken: 1'b0, flush: 1'b0,
				busy: 1'b0, sreg: cbu_pkg::SREG_RST};
		end else begin
			s_q <= s_d;
		end
	end

	assign program_counter = s_q.pc;
	assign branch_taken = s_q.taken;
	assign flush_fetch = s_q.flush;
	assign busy = s_q.busy;
	assign sreg_out = s_q.sreg;

	// timing of the taken and untaken paths
	taken_two_cyc_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ15]
		(accept && cond)
			|=> (s_q.st == cbu_pkg::CBU_FLUSH) ##1 (s_q.st == cbu_pkg::CBU_RUN))
		else $error("taken branch not two cycles");

	fall_through_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ14]
		(accept && !cond) |=> (program_counter == $past(program_counter) + cbu_pkg::PC_STEP)
			&& !branch_taken)
		else $error("untaken branch did not fall through");

	pc_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ14]
		!accept
			|=> program_counter == $past(program_counter))
		else $error("pc moved without a branch");

	// the word fetched behind a taken branch must not act, whatever it decodes to
	flush_drop_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ15]
		(busy && req_valid)
			|=> !branch_taken && program_counter == $past(program_counter))
		else $error("request in flush cycle acted");

	flags_kept_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ13]
		1'b1
			|=> (sreg_out == $past(sreg_in)))
		else $error("status flags altered");

	// per-condition decode against the live flags
	carry_set_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ1]
		(accept && req.op == cbu_pkg::CBU_CARRY_SET)
			|=> branch_taken == $past(sreg_in[cbu_pkg::FLAG_C]))
		else $error("carry set branch wrong");

	carry_clr_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ2]
		(accept && req.op == cbu_pkg::CBU_CARRY_CLR)
			|=> branch_taken == !$past(sreg_in[cbu_pkg::FLAG_C]))
		else $error("carry clear branch wrong");

	uns_ge_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ3]
		(accept && req.op == cbu_pkg::CBU_UNS_GE)
			|=> branch_taken == !$past(sreg_in[cbu_pkg::FLAG_C]))
		else $error("unsigned ge branch wrong");

	uns_lt_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ4]
		(accept && req.op == cbu_pkg::CBU_UNS_LT)
			|=> branch_taken == $past(sreg_in[cbu_pkg::FLAG_C]))
		else $error("unsigned lt branch wrong");

	neg_branch_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ5]
		(accept && req.op == cbu_pkg::CBU_NEG)
			|=> branch_taken == $past(sreg_in[cbu_pkg::FLAG_N]))
		else $error("negative branch wrong");

	pos_branch_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ6]
		(accept && req.op == cbu_pkg::CBU_POS)
			|=> branch_taken == !$past(sreg_in[cbu_pkg::FLAG_N]))
		else $error("positive branch wrong");

	signed_ge_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ7]
		(accept && req.op == cbu_pkg::CBU_SGN_GE) |=> branch_taken
			== !($past(sreg_in[cbu_pkg::FLAG_N]) ^ $past(sreg_in[cbu_pkg::FLAG_V])))
		else $error("signed ge branch wrong");

	signed_lt_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ8]
		(accept && req.op == cbu_pkg::CBU_SGN_LT) |=> branch_taken
			== ($past(sreg_in[cbu_pkg::FLAG_N]) ^ $past(sreg_in[cbu_pkg::FLAG_V])))
		else $error("signed lt branch wrong");

	half_set_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ9]
		(accept && req.op == cbu_pkg::CBU_HALF_SET)
			|=> branch_taken == $past(sreg_in[cbu_pkg::FLAG_H]))
		else $error("half carry set branch wrong");

	half_clr_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ10]
		(accept && req.op == cbu_pkg::CBU_HALF_CLR)
			|=> branch_taken == !$past(sreg_in[cbu_pkg::FLAG_H]))
		else $error("half carry clear branch wrong");

	xfer_set_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ11]
		(accept && req.op == cbu_pkg::CBU_XFER_SET)
			|=> branch_taken == $past(sreg_in[cbu_pkg::FLAG_T]))
		else $error("transfer set branch wrong");

	xfer_clr_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ12]
		(accept && req.op == cbu_pkg::CBU_XFER_CLR)
			|=> branch_taken == !$past(sreg_in[cbu_pkg::FLAG_T]))
		else $error("transfer clear branch wrong");

	ovf_set_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ16]
		(accept && req.op == cbu_pkg::CBU_OVF_SET)
			|=> branch_taken == $past(sreg_in[cbu_pkg::FLAG_V]))
		else $error("overflow set branch wrong");

	// target arithmetic is checked with a signed cast, independent of ofs_ext
	target_calc_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ16]
		(accept && cond) |=> program_counter == 16'($past(program_counter)
			+ 16'($signed($past(req.offset))) + cbu_pkg::PC_STEP))
		else $error("branch target wrong");

	flush_pair_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ15]
		branch_taken
			|-> (flush_fetch && busy) ##1 (!busy && !branch_taken))
		else $error("taken branch flush not one cycle");

	taken_c: cover property (@(posedge mclk) disable iff (!rst_n) accept && cond);
	not_taken_c: cover property (@(posedge mclk) disable iff (!rst_n) accept && !cond);
	back_taken_c: cover property (@(posedge mclk) disable iff (!rst_n)
		(accept && cond && req.offset[cbu_pkg::OFS_W-1]));
	ovf_taken_c: cover property (@(posedge mclk) disable iff (!rst_n)
		(accept && cond && req.op == cbu_pkg::CBU_OVF_SET));
	refused_req_c: cover property (@(posedge mclk) disable iff (!rst_n)
		(busy && req_valid && req.op != cbu_pkg::CBU_NONE));
endmodule : cbu_branch
`default_nettype wire

// ===== test/tb.sv
// Purpose: random self-checking bench for the conditional branch unit
// Assumes: one-cycle answer, one flush cycle after a taken branch
// Notes: a long random run covers every op with both flag senses
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
	localparam int C = cbu_pkg::FLAG_C;
	localparam int N = cbu_pkg::FLAG_N;
	localparam int V = cbu_pkg::FLAG_V;
	localparam int H = cbu_pkg::FLAG_H;
	localparam int T = cbu_pkg::FLAG_T;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	cbu_pkg::cbu_req_s req = '0;
	logic [7:0] sreg_in = 8'h00;
	logic [cbu_pkg::PC_W-1:0] program_counter;
	logic branch_taken;
	logic flush_fetch;
	logic busy;
	logic [7:0] sreg_out;
	integer seed = 90;
	integer n_mismatch = 0;
	integer checks = 0;
	logic [cbu_pkg::PC_W-1:0] pc_m;
	logic tk_m;
	logic acc;
	logic [7:0] sr_m;

	always #12.5 mclk = ~mclk;

	cbu_branch DUT (
		.mclk(mclk),
		.rst_n(rst_n),
		.req_valid(req_valid),
		.req(req),
		.sreg_in(sreg_in),
		.program_counter(program_counter),
		.branch_taken(branch_taken),
		.flush_fetch(flush_fetch),
		.busy(busy),
		.sreg_out(sreg_out)
	);

	function automatic logic cond(input logic [3:0] o, input logic [7:0] s);
		case (o)
			cbu_pkg::CBU_CARRY_SET, cbu_pkg::CBU_UNS_LT: return s[C];
			cbu_pkg::CBU_CARRY_CLR, cbu_pkg::CBU_UNS_GE: return !s[C];
			cbu_pkg::CBU_NEG: return s[N];
			cbu_pkg::CBU_POS: return !s[N];
			cbu_pkg::CBU_SGN_GE: return !(s[N] ^ s[V]);
			cbu_pkg::CBU_SGN_LT: return s[N] ^ s[V];
			cbu_pkg::CBU_HALF_SET: return s[H];
			cbu_pkg::CBU_HALF_CLR: return !s[H];
			cbu_pkg::CBU_XFER_SET: return s[T];
			cbu_pkg::CBU_XFER_CLR: return !s[T];
			cbu_pkg::CBU_OVF_SET: return s[V];
			default: return 1'b0;
		endcase
	endfunction : cond

	task results;
		if (n_mismatch == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	// the main run lasts about 2005 cycles, so this only fires on a hang
	initial begin
		#(2200 * 25);
		n_mismatch++;
		results();
	end

	initial begin
		pc_m = 16'h0000;
		tk_m = 1'b0;
		sr_m = 8'h00;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		@(negedge mclk);
		`CHK(program_counter, 16'h0000)
		repeat (2000) begin
			@(posedge mclk);
			// a request landing in the flush cycle is dropped
			acc = req_valid && req.op != cbu_pkg::CBU_NONE && !tk_m;
			if (acc && cond(req.op, sreg_in)) begin
				pc_m = pc_m + {{9{req.offset[6]}}, req.offset} + 16'h0001;
				tk_m = 1'b1;
			end else begin
				if (acc)
					pc_m = pc_m + 16'h0001;
				tk_m = 1'b0;
			end
			sr_m = sreg_in;
			req_valid <= ($random(seed) & 3) != 0;
			req.op <= cbu_pkg::cbu_op_e'(4'(unsigned'($random(seed)) % 14));
			req.offset <= 7'($random(seed));
			sreg_in <= 8'($random(seed));
			@(negedge mclk);
			`CHK(program_counter, pc_m)
			`CHK(branch_taken, tk_m)
			`CHK(flush_fetch, tk_m)
			`CHK(busy, tk_m)
			`CHK(sreg_out, sr_m)
		end
		results();
	end
endmodule : tb
`default_nettype wire
